/* File: core/serial_step_angle_control.v */
// Serial step angle control: shift register, run/table decode, index.
// Assumes a host on a three-wire serial link; serial pins are asynchronous
// to sys_clk and are sampled with three flops each.
// Outputs are registered; the phase outputs lag the index by one cycle.
`timescale 1ns/10ps
`default_nettype none
`include "step_angle_consts.vh"

module serial_step_angle_control #(
    parameter FRAME = `FRAME_BITS,
    parameter W     = 6
) (
    // Clock and reset
    input  wire         sys_clk,
    input  wire         reset,
    // Serial link from host
    input  wire         sck,
    input  wire         sdi,
    input  wire         serial_strobe_low,
    // Motor drive outputs
    output wire [W-1:0] phase_a_current,
    output wire         phase_a_dir,
    output wire [W-1:0] phase_b_current,
    output wire         phase_b_dir,
    // Status
    output wire [5:0]   step_angle,
    output reg          step_pulse,
    output reg  [FRAME-1:0] last_frame
);
    // =================================================================
    // Input synchronisers
    reg [2:0] sck_sync_reg;
    reg [2:0] sdi_sync_reg;
    reg [2:0] stb_sync_reg;

    // Serial clock pin through three flops, idles low
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sck_sync_reg <= `SYNC_LOW;
        end else begin
            sck_sync_reg <= {sck_sync_reg[1:0], sck};
        end
    end

    // Serial data pin through three flops
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sdi_sync_reg <= `SYNC_LOW;
        end else begin
            sdi_sync_reg <= {sdi_sync_reg[1:0], sdi};
        end
    end

    // Strobe pin through three flops; idles high so reset gives no false edge
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stb_sync_reg <= `SYNC_HIGH;
        end else begin
            stb_sync_reg <= {stb_sync_reg[1:0], serial_strobe_low};
        end
    end

    // =================================================================
    // Level filter and edge events

    // Second and third stages show the same level
    function stages_agree;
        input [2:0] s;
        begin
            stages_agree = (s[1] == s[2]);
        end
    endfunction

    // Agreed level has just moved to the wanted one, away from the held one
    function moved_to;
        input [2:0] s;
        input       held;
        input       want;
        begin
            moved_to = stages_agree(s) && (s[2] == want) && (held != want);
        end
    endfunction

    // Filtered levels: change once second and third stages agree
    reg  sck_lvl_reg;
    reg  stb_lvl_reg;
    reg  sdi_lvl_reg;
    wire sck_agree = stages_agree(sck_sync_reg);
    wire stb_agree = stages_agree(stb_sync_reg);
    wire sdi_agree = stages_agree(sdi_sync_reg);

    // Held serial clock level
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sck_lvl_reg <= `LVL_LOW;
        end else if (sck_agree) begin
            sck_lvl_reg <= sck_sync_reg[2];
        end
    end

    // Held strobe level, idle high
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stb_lvl_reg <= `LVL_HIGH;
        end else if (stb_agree) begin
            stb_lvl_reg <= stb_sync_reg[2];
        end
    end

    // Held data level, taken by the shift register at clock rises
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sdi_lvl_reg <= `LVL_LOW;
        end else if (sdi_agree) begin
            sdi_lvl_reg <= sdi_sync_reg[2];
        end
    end

    // Edge events on the filtered levels; a pin level must hold
    // for about two sys_clk periods before it counts, so short
    // glitches on the link never make an edge
    wire sck_rise = moved_to(sck_sync_reg, sck_lvl_reg, `LVL_HIGH);
    wire stb_fall = moved_to(stb_sync_reg, stb_lvl_reg, `LVL_LOW);
    wire stb_rise = moved_to(stb_sync_reg, stb_lvl_reg, `LVL_HIGH);

    // =================================================================
    // Frame shift register
    localparam [2:0] S_IDLE  = 3'h1;
    localparam [2:0] S_SHIFT = 3'h2;
    localparam [2:0] S_DONE  = 3'h4;

    reg [2:0]       state_reg;
    reg [2:0]       state_next;
    reg [FRAME-1:0] shift_reg;
    reg [4:0]       count_reg;

    wire frame_full = (count_reg == FRAME[4:0]);

    // Frame state: strobe low opens, strobe high closes
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:  if (stb_fall) state_next = S_SHIFT;
            S_SHIFT: if (stb_rise) state_next = S_DONE;
            S_DONE:  state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    // Shift on serial clock rising edges; clock rate only affects shifting
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= S_IDLE;
            shift_reg <= {FRAME{1'b0}};
            count_reg <= `CNT_RESET;
        end else begin
            state_reg <= state_next;
            if (stb_fall) begin
                count_reg <= `CNT_RESET;
            end else if (state_reg == S_SHIFT && sck_rise) begin
                shift_reg <= {shift_reg[FRAME-2:0], sdi_lvl_reg};
                if (!frame_full) count_reg <= count_reg + 5'h01;
            end
        end
    end

    // =================================================================
    // Command decode at strobe rise
    wire [1:0] cmd      = shift_reg[`CMD_HI:`CMD_LO];
    wire       complete = (state_reg == S_SHIFT) && stb_rise && frame_full;
    wire       run_wr   = complete && (cmd == `CMD_RUN);
    wire       tbl_wr   = complete && (cmd == `CMD_TABLE);
    wire [5:0] sc       = shift_reg[`SC_HI:`SC_LO];

    // Step angle index
    reg [5:0] angle_reg;

    // Signed change added with natural 6-bit wrap
    // Only a run frame of at least sixteen bits, closed by the strobe, moves it
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            angle_reg <= `IDX_RESET;
        end else if (run_wr) begin
            angle_reg <= angle_reg + sc;
        end
    end

    // Pulse in the cycle in which the new index first shows
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            step_pulse <= 1'b0;
        end else begin
            step_pulse <= run_wr;
        end
    end

    // Copy of the last complete frame, whatever its command
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            last_frame <= {FRAME{1'b0}};
        end else if (complete) begin
            last_frame <= shift_reg;
        end
    end

    // Index drives the table lookup and the status port
    assign step_angle = angle_reg;

    // =================================================================
    // Phase current lookup
    phase_table #(
        .W (W)
    ) u_table (
        .sys_clk (sys_clk),
        .reset   (reset),
        .wr_en   (tbl_wr),
        .wr_idx  (shift_reg[`TBL_IDX_HI:`TBL_IDX_LO]),
        .wr_val  (shift_reg[`TBL_VAL_HI:`TBL_VAL_LO]),
        .angle   (angle_reg),
        .cur_a   (phase_a_current),
        .dir_a   (phase_a_dir),
        .cur_b   (phase_b_current),
        .dir_b   (phase_b_dir)
    );
endmodule // serial_step_angle_control
`default_nettype wire

/* File: core/step_angle_consts.vh */
// Constants for the serial step angle control block.
// Assumes inclusion by the design files under core/; definitions only.
//
// What this block does
// - The step angle index stays in 0..63 and every change wraps modulo 64.
// - The step change is taken from bits 0 to 5 of the run register.
// - The step change is a signed two's complement value added to the index.
// - One unit up is one sixteenth microstep forward, one unit down the same in reverse.
// - The index moves only on the strobe rising edge that ends a run register write.
// - The step rate depends only on strobe rising edges, never on the serial clock rate.
// - All features are controlled over the serial link, with no separate control pins.
// - The phase current table can be reprogrammed serially and then replaces the sine profile.
// - Each phase current is a 6-bit value looked up in the phase current table.
// - Phase A current is read from the table at the present step angle index, phase B at the index plus 16.
`ifndef STEP_ANGLE_CONSTS_VH
`define STEP_ANGLE_CONSTS_VH

// =====================================================================
// Serial frame layout
`define FRAME_BITS       16
`define CMD_HI           15
`define CMD_LO           14
`define CMD_RUN          2'h3
`define CMD_TABLE        2'h2
`define SC_HI            5
`define SC_LO            0
`define TBL_IDX_HI       13
`define TBL_IDX_LO       10
`define TBL_VAL_HI       5
`define TBL_VAL_LO       0

// =====================================================================
// Index and table
`define IDX_RESET        6'h00
`define IDX_QUAD_MSB     4
`define IDX_HALF_MSB     5
`define QUAD_MASK        4'hF
`define DAC_ZERO         6'h00
`define CNT_RESET        5'h00
`define PHASE_B_SHIFT    6'h10

// =====================================================================
// Pin sampling idle levels
`define SYNC_LOW         3'h0
`define SYNC_HIGH        3'h7
`define LVL_LOW          1'b0
`define LVL_HIGH         1'b1

`endif

/* File: core/phase_table.v */
// Phase current table: 16 programmable quarter-wave entries plus zero.
// Assumes writes come from the serial decoder on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "step_angle_consts.vh"

module phase_table #(
    parameter W = 6
) (
    // Clock and reset
    input  wire         sys_clk,
    input  wire         reset,
    // Programming port
    input  wire         wr_en,
    input  wire [3:0]   wr_idx,
    input  wire [W-1:0] wr_val,
    // Lookup
    input  wire [5:0]   angle,
    output reg  [W-1:0] cur_a,
    output reg          dir_a,
    output reg  [W-1:0] cur_b,
    output reg          dir_b
);
    reg [W-1:0] tbl_reg [0:15];
    integer     i;

    // Default quarter-sine profile, entry k holds table step k+1
    function [W-1:0] dflt;
        input [3:0] k;
        begin
            case (k)
                4'h0: dflt = 6'h05;
                4'h1: dflt = 6'h0B;
                4'h2: dflt = 6'h12;
                4'h3: dflt = 6'h17;
                4'h4: dflt = 6'h1D;
                4'h5: dflt = 6'h23;
                4'h6: dflt = 6'h28;
                4'h7: dflt = 6'h2C;
                4'h8: dflt = 6'h30;
                4'h9: dflt = 6'h34;
                4'hA: dflt = 6'h37;
                4'hB: dflt = 6'h3A;
                4'hC: dflt = 6'h3C;
                4'hD: dflt = 6'h3E;
                4'hE: dflt = 6'h3F;
                default: dflt = 6'h3F;
            endcase
        end
    endfunction

    // Magnitude of phase A at a step angle, by quadrant mirroring
    function [W-1:0] mag;
        input [5:0] a;
        reg   [3:0] q;
        begin
            q = a[3:0];
            if (a[`IDX_QUAD_MSB] == 1'b0) begin
                mag = (q == 4'h0) ? `DAC_ZERO : tbl_reg[q - 4'h1];
            end else begin
                mag = (q == 4'h0) ? tbl_reg[`QUAD_MASK] : tbl_reg[`QUAD_MASK - q];
            end
        end
    endfunction

    // Programmable entries, loaded serially
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (i = 0; i < 16; i = i + 1) tbl_reg[i] <= dflt(i[3:0]);
        end else if (wr_en) begin
            tbl_reg[wr_idx] <= wr_val;
        end
    end

    // Both phases read from the present index, B shifted forward by 16
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cur_a <= `DAC_ZERO;
            cur_b <= `DAC_ZERO;
            dir_a <= 1'b0;
            dir_b <= 1'b0;
        end else begin
            cur_a <= mag(angle);
            cur_b <= mag(angle + `PHASE_B_SHIFT);
            dir_a <= angle[`IDX_HALF_MSB];
            dir_b <= angle[`IDX_HALF_MSB] ^ angle[`IDX_QUAD_MSB];
        end
    end
endmodule // phase_table
`default_nettype wire

/* File: dv/serial_step_angle_control_props.sv */
// Checker for the serial step angle control ports.
// Assumes it is bound to every instance of the block.
`timescale 1ns/10ps
`default_nettype none
module step_angle_props #(
    parameter FRAME = 16,
    parameter W     = 6
) (
    // Clock, reset and serial pins
    input wire logic             sys_clk,
    input wire logic             reset,
    input wire logic             sck,
    input wire logic             sdi,
    input wire logic             serial_strobe_low,
    // Outputs
    input wire logic [W-1:0]     phase_a_current,
    input wire logic             phase_a_dir,
    input wire logic [W-1:0]     phase_b_current,
    input wire logic             phase_b_dir,
    input wire logic [5:0]       step_angle,
    input wire logic             step_pulse,
    input wire logic [FRAME-1:0] last_frame
);
    logic [3:0] since_rise;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ========
    // Cycles since the strobe pin rose
    always @(posedge sys_clk or posedge reset) begin
        if (reset) since_rise <= 4'hF;
        else if ($rose(serial_strobe_low)) since_rise <= 4'h0;
        else if (since_rise != 4'hF) since_rise <= since_rise + 4'h1;
    end
    a_angle_adds_sc: assert property (step_pulse |-> step_angle == $past(step_angle, 2) + last_frame[5:0])
        else $error("index did not move by the step change");
    a_move_has_pulse: assert property ($changed(step_angle) |-> step_pulse)
        else $error("index moved without a step pulse");
    a_pulse_one_cycle: assert property (step_pulse |=> !step_pulse)
        else $error("step pulse longer than one cycle");
    a_run_cmd_only: assert property (step_pulse |-> last_frame[15:14] == 2'h3)
        else $error("step taken on a non-run frame");
    a_move_after_rise: assert property ($changed(step_angle) |-> since_rise inside {[4'h2:4'h7]})
        else $error("index moved away from a strobe rise");
    a_reset_zero: assert property ($fell(reset) |-> step_angle == 6'h00 && !step_pulse)
        else $error("index not zero after reset");
    a_dir_follows: assert property (phase_a_dir == $past(step_angle[5]) && phase_b_dir == $past(^step_angle[5:4]))
        else $error("phase direction does not follow index");
    a_a_zero_pts: assert property ($past(step_angle[4:0]) == 5'h00 |-> phase_a_current == 6'h00)
        else $error("phase A not zero at its zero points");
    a_b_zero_pts: assert property ($past(step_angle[4:0]) == 5'h10 |-> phase_b_current == 6'h00)
        else $error("phase B not zero at its zero points");
    c_reverse: cover property (step_pulse && last_frame[5]);
    c_wrap: cover property (step_pulse && step_angle == 6'h00);
    c_peak_a: cover property (step_pulse && step_angle == 6'h30);
endmodule // step_angle_props
bind serial_step_angle_control step_angle_props #(.FRAME(FRAME), .W(W)) u_props (
    .sys_clk(sys_clk), .reset(reset), .sck(sck), .sdi(sdi), .serial_strobe_low(serial_strobe_low),
    .phase_a_current(phase_a_current), .phase_a_dir(phase_a_dir), .phase_b_current(phase_b_current),
    .phase_b_dir(phase_b_dir), .step_angle(step_angle), .step_pulse(step_pulse), .last_frame(last_frame));
`default_nettype wire

/* File: dv/host_link_model.sv */
// Host side of the serial link: frames sent MSB first.
// Assumes callers give a half period of at least 30 ns.
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
    // Clock that launches frames
    input  wire logic sys_clk,
    // Serial pins
    output var  logic sck,
    output var  logic sdi,
    output var  logic serial_strobe_low
);
    // Idle levels
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        serial_strobe_low = 1'b1;
    end
    // One frame; clock stands low and data inverts outside frames
    task automatic send(input logic [15:0] w, input integer n, input realtime hp);
        integer b;
        @(posedge sys_clk);
        #1 serial_strobe_low = 1'b0;
        for (b = n - 1; b >= 0; b = b - 1) begin
            #(hp) sdi = w[b];
            #(hp) sck = 1'b1;
            #(hp) sck = 1'b0;
        end
        #(hp) serial_strobe_low = 1'b1;
        sdi = ~sdi;
        #60;
    endtask
endmodule // host_link_model
`default_nettype wire

/* File: dv/serial_step_angle_control_test.sv */
// Self-checking bench for the serial step angle control block.
// Assumes the host model drives the serial pins.
`timescale 1ns/10ps
`default_nettype none
module serial_step_angle_control_test;
    logic        sys_clk   = 1'b0;
    logic        reset     = 1'b1;
    wire         sck, sdi, serial_strobe_low, pa_dir, pb_dir, step_pulse;
    wire  [5:0]  pa_cur, pb_cur, angle;
    wire  [15:0] last_frame;
    integer      n_mismatch = 0;
    integer      n_tests    = 0;
    integer      seed       = 32'hD5F0;
    integer      i, r;
    logic [5:0]  exp_angle  = 6'h00;
    logic [5:0]  sc_list [0:7] = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h30, 6'h38, 6'h3C, 6'h3E};
    logic [5:0]  dflt_pt [0:15] = '{6'h05, 6'h0B, 6'h12, 6'h17, 6'h1D, 6'h23, 6'h28, 6'h2C,
                                    6'h30, 6'h34, 6'h37, 6'h3A, 6'h3C, 6'h3E, 6'h3F, 6'h3F};
    always #5 sys_clk = ~sys_clk;
    host_link_model host (.sys_clk(sys_clk), .sck(sck), .sdi(sdi), .serial_strobe_low(serial_strobe_low));
    serial_step_angle_control DUT (.sys_clk(sys_clk), .reset(reset), .sck(sck), .sdi(sdi),
        .serial_strobe_low(serial_strobe_low), .phase_a_current(pa_cur), .phase_a_dir(pa_dir),
        .phase_b_current(pb_cur), .phase_b_dir(pb_dir), .step_angle(angle), .step_pulse(step_pulse),
        .last_frame(last_frame));
    // ========
    // Helpers
    function automatic logic [5:0] next_angle(input logic [5:0] a, input logic [5:0] sc);
        return a + sc;
    endfunction
    // Default phase A magnitude: rises over one quarter cycle, mirrors over the next
    function automatic logic [5:0] exp_cur(input logic [5:0] a);
        int m;
        m = (a[4:0] > 5'h10) ? 32 - a[4:0] : a[4:0];
        return (m == 0) ? 6'h00 : dflt_pt[m - 1];
    endfunction
    // Current reversed in the second half of the electrical cycle
    function automatic logic exp_dir(input logic [5:0] a);
        return (a >= 6'h20);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        n_tests = n_tests + 1;
        if (seen !== expd) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic frame(input logic [15:0] w, input integer n, input realtime hp);
        host.send(w, n, hp);
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic run(input logic [5:0] sc, input logic [7:0] cfg, input realtime hp);
        exp_angle = next_angle(exp_angle, sc);
        frame({2'h3, cfg, sc}, 16, hp);
        check(angle, exp_angle);
        check(last_frame, {2'h3, cfg, sc});
    endtask
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ========
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 reset = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check(angle, 6'h00);
        check(pb_cur, 6'h3F);
        check(pa_cur, 6'h00);
        $display("Reset test done");
        run(6'h3F, 8'h00, 62.5);
        run(6'h01, 8'hA5, 62.5);
        for (i = 0; i < 8; i = i + 1) run(sc_list[i], 8'h00, 62.5);
        $display("Step size test done");
        for (i = 0; i < 20; i = i + 1) begin
            r = $random(seed);
            run(r[5:0], r[13:6], 40.0 + r[19:14]);
            check(pa_cur, exp_cur(exp_angle));
            check(pb_cur, exp_cur(exp_angle + 6'h10));
            check(pa_dir, exp_dir(exp_angle));
            check(pb_dir, exp_dir(exp_angle + 6'h10));
            repeat (r[22:20]) @(posedge sys_clk);
        end
        $display("Random test done");
        frame({2'h3, 8'h00, 6'h05}, 12, 62.5);
        check(angle, exp_angle);
        frame({2'h2, 4'hF, 4'h0, 6'h2A}, 16, 62.5);
        check(angle, exp_angle);
        run(6'h10 - exp_angle, 8'h00, 62.5);
        check(pa_cur, 6'h2A);
        check(pa_dir, 1'b0);
        run(6'h20, 8'h00, 62.5);
        check(pa_cur, 6'h2A);
        check(pa_dir, 1'b1);
        $display("Refusal and table test done");
        finish_test;
    end
    // Watchdog
    initial begin
        #500000;
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        finish_test;
    end
endmodule // serial_step_angle_control_test
`default_nettype wire
